// >>> rtl/flash_host.sv
`timescale 1ns/10ps
`include "flash_host_map.svh"
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - erase and program need a two-write command sequence
// - reads return data chosen by last read-mode command written
// - host asserts chip enable, then output enable after the setup time, to read
// - during reads write enable stays high and reset_powerdown_n high
module flash_host
  import flash_host_pkg::*;
#(
  parameter int ADDR_W = 20,
  parameter int DATA_W = 16
)(
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst,
  input  wire logic              i_req,
  input  wire op_type            i_op,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic [DATA_W-1:0] i_wdata2,
  input  wire logic              i_set_mode,
  input  wire read_mode_type     i_mode,
  input  wire logic              i_wp_n,
  input  wire logic              i_ready_busy_n,
  input  wire logic [DATA_W-1:0] i_data_bus,
  output logic                   o_ready,
  output logic                   o_done,
  output logic [DATA_W-1:0]      o_rdata,
  output logic                   o_busy,
  output read_mode_type          o_mode,
  output logic [ADDR_W-1:0]      o_addr,
  output logic [DATA_W-1:0]      o_data_bus,
  output logic                   o_data_oe,
  output logic                   o_ce_n,
  output logic                   o_oe_n,
  output logic                   o_we_n,
  output logic                   o_reset_powerdown_n,
  output logic                   o_wp_n
);
  // refused at elaboration: the low-byte masking needs at least a full byte
  if (DATA_W < 8 || ADDR_W < 1)
  begin
    $error("flash_host: unsupported width");
  end

  localparam logic [`TIMER_W-1:0] SETUP_CYC  = `TIMER_W'(`CYC_MIN(`T_SETUP_NS));
  localparam logic [`TIMER_W-1:0] STROBE_CYC = `TIMER_W'(`CYC_MIN(`T_STROBE_NS));
  localparam logic [`TIMER_W-1:0] HOLD_CYC   = `TIMER_W'(`CYC_MIN(`T_HOLD_NS));
  localparam logic [`TIMER_W-1:0] RST_CYC    = `TIMER_W'(`CYC_MIN(`T_RESET_LOW_NS));
  localparam logic [`TIMER_W-1:0] WAKE_CYC   = `TIMER_W'(`CYC_MIN(`T_WAKE_NS));

  typedef enum logic [2:0] {st_idle, st_setup, st_strobe, st_hold, st_rst_low, st_wake} state_type;

  state_type            state;
  logic [`TIMER_W-1:0]  timer;
  logic                 second;
  logic                 is_write;
  logic [DATA_W-1:0]    sample;
  logic                 busy_sync;

  // pins from the device are asynchronous
  // inverted ahead of the sync so its reset value reads as a released pin, not a false busy
  sync2 #(.WIDTH(1)) u_sync_rb
  (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_async   (~i_ready_busy_n),
    .o_sync    (busy_sync)
  );
  sync2 #(.WIDTH(DATA_W)) u_sync_dq
  (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_async   (i_data_bus),
    .o_sync    (sample)
  );

  function automatic logic [DATA_W-1:0] shape_read(input logic [DATA_W-1:0] d, input read_mode_type m);
    shape_read = d;
    if (m != rmode_array)
    begin
      for (int i = `LOW_BYTE_MSB + 1; i < DATA_W; i++)
        shape_read[i] = 1'b0;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // busy flag from the open-drain pin, pulled up when released
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      o_busy <= 1'b0;
    else
      o_busy <= busy_sync;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      o_wp_n <= 1'b0;
    else
      o_wp_n <= i_wp_n;
  end

  //////////////////////////////////////////////////////////////////////////////
  // read mode follows the last read-mode command; reset returns it to array
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      o_mode <= rmode_array;
    else if (state == st_wake)
      o_mode <= rmode_array;
    else if (o_ready && i_req && i_set_mode)
      o_mode <= i_mode;
  end

  //////////////////////////////////////////////////////////////////////////////
  // bus cycle sequencer
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      state               <= st_rst_low;
      timer               <= '0;
      second              <= 1'b0;
      is_write            <= 1'b0;
      o_ready             <= 1'b0;
      o_done              <= 1'b0;
      o_rdata             <= '0;
      o_addr              <= '0;
      o_data_bus          <= '0;
      o_data_oe           <= 1'b0;
      o_ce_n              <= 1'b1;
      o_oe_n              <= 1'b1;
      o_we_n              <= 1'b1;
      o_reset_powerdown_n <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      timer  <= timer + `TIMER_W'(1);
      unique case (state)
        st_idle:
        begin
          timer <= '0;
          if (i_req)
          begin
            o_ready <= 1'b0;
            o_addr  <= i_addr;
            second  <= 1'b0;
            unique case (i_op)
              op_reset:
              begin
                o_reset_powerdown_n <= 1'b0;
                state               <= st_rst_low;
              end
              op_read:
              begin
                is_write <= 1'b0;
                state    <= st_setup;
              end
              op_write, op_two_step:
              begin
                is_write   <= 1'b1;
                o_data_bus <= i_wdata;
                o_data_oe  <= 1'b1;
                state      <= st_setup;
              end
            endcase
            if (i_op == op_two_step)
              second <= 1'b1;
          end
        end
        st_setup:
        begin
          o_ce_n <= 1'b0;
          if (timer >= SETUP_CYC)
          begin
            timer <= '0;
            if (is_write)
              o_we_n <= 1'b0;
            else
              o_oe_n <= 1'b0;
            state <= st_strobe;
          end
        end
        st_strobe:
        begin
          if (timer >= STROBE_CYC)
          begin
            timer <= '0;
            // rising write strobe latches the cycle, so data can drop after hold
            o_we_n <= 1'b1;
            if (!is_write)
              o_rdata <= shape_read(sample, o_mode);
            o_oe_n <= 1'b1;
            state  <= st_hold;
          end
        end
        st_hold:
        begin
          if (timer >= HOLD_CYC)
          begin
            timer  <= '0;
            o_ce_n <= 1'b1;
            if (second)
            begin
              // confirm write of the two-step sequence, no new request taken
              second     <= 1'b0;
              o_data_bus <= i_wdata2;
              state      <= st_setup;
            end
            else
            begin
              o_data_oe <= 1'b0;
              o_done    <= 1'b1;
              o_ready   <= 1'b1;
              state     <= st_idle;
            end
          end
        end
        st_rst_low:
        begin
          o_reset_powerdown_n <= 1'b0;
          if (timer >= RST_CYC)
          begin
            timer               <= '0;
            o_reset_powerdown_n <= 1'b1;
            state               <= st_wake;
          end
        end
        st_wake:
        begin
          // wake-up interval before first access after power-down exit
          if (timer >= WAKE_CYC)
          begin
            timer   <= '0;
            o_done  <= 1'b1;
            o_ready <= 1'b1;
            state   <= st_idle;
          end
        end
        default:
          state <= st_idle;
      endcase
    end
  end
endmodule

// >>> rtl/flash_host_map.svh
`ifndef FLASH_HOST_MAP_SVH
`define FLASH_HOST_MAP_SVH
// bus cycle timing, in ns, at the system clock rate
`define CLK_PERIOD_NS      40
`define T_SETUP_NS         80
`define T_STROBE_NS        120
`define T_HOLD_NS          40
`define T_RESET_LOW_NS     100
`define T_WAKE_NS          1000
`define CYC_MIN(ns)        (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// two-step sequence first-step codes are supplied by the user port
`define LOW_BYTE_MSB       7
`define TIMER_W            8
`endif

// >>> rtl/flash_host_pkg.sv
package flash_host_pkg;
  typedef enum logic [1:0] {op_read, op_write, op_two_step, op_reset} op_type;
  typedef enum logic [1:0] {rmode_array, rmode_ident, rmode_status} read_mode_type;
endpackage

// >>> rtl/sync2.sv
`timescale 1ns/10ps
module sync2 #(
  parameter int WIDTH = 1
)(
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;
  // first stage is read only by the second
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      meta   <= '0;
      o_sync <= '0;
    end
    else
    begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule

// >>> tb/flash_dev_model.sv
`timescale 1ns/10ps
module flash_dev_model #(
  parameter int         BUSY_NS  = 3000,
  parameter logic [7:0] CMD_PROG = 8'h11,
  parameter logic [7:0] CMD_ARR  = 8'h22,
  parameter logic [7:0] CMD_ID   = 8'h33,
  parameter logic [7:0] CMD_STAT = 8'h44,
  parameter logic [7:0] ID_CODE  = 8'h5a // arbitrary value
)(
  input  wire logic        i_ce_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  input  wire logic        i_rp_n,
  input  wire logic        i_wp_n,
  input  wire logic        i_vpp_ok,
  input  wire logic [19:0] i_addr,
  input  wire logic [15:0] i_dq,
  output logic [15:0]      o_dq,
  output logic             o_ready_busy_n
);
  logic [15:0] mem [16];
  logic [1:0]  mode = 2'h0;
  logic        armed = 1'h0;
  logic        busy = 1'h0;
  logic [15:0] rd;
  initial
    foreach (mem[k]) mem[k] = {8'(k), 8'hc3};
  // words 0 and 1 stand for the locked boot blocks
  always @(posedge i_we_n)
    if (!i_ce_n && i_rp_n)
    begin
      // a refused alteration leaves the pin released, so status reads stay ready
      if (armed && i_vpp_ok && (i_wp_n || i_addr > 20'h1))
      begin
        mem[i_addr[3:0]] = i_dq;
        busy = 1'h1;
      end
      armed = !armed && i_dq[7:0] == CMD_PROG;
      if (i_dq[7:0] == CMD_ARR) mode = 2'h0;
      if (i_dq[7:0] == CMD_ID) mode = 2'h1;
      if (i_dq[7:0] == CMD_STAT) mode = 2'h2;
    end
  always @(posedge busy)
  begin
    #(BUSY_NS);
    busy = 1'h0;
  end
  always @(negedge i_rp_n)
  begin
    busy = 1'h0;
    armed = 1'h0;
    mode = 2'h0;
  end
  // upper byte is junk in status and identifier modes
  always @*
    case (mode)
      2'h1: rd = {8'ha5, ID_CODE};
      2'h2: rd = {8'ha5, busy ? 8'h00 : 8'h80};
      default: rd = mem[i_addr[3:0]];
    endcase
  // a released bus shows the inverse, so stale values never pass
  assign o_dq = (!i_ce_n && !i_oe_n && i_rp_n) ? rd : ~rd;
  assign o_ready_busy_n = !busy;
endmodule

// >>> tb/flash_host_checker.sv
`timescale 1ns/10ps
module flash_host_checker
  import flash_host_pkg::*;
#(
  parameter int ADDR_W = 20,
  parameter int DATA_W = 16
)(
  input wire logic              i_clk_sys,
  input wire logic              i_rst,
  input wire logic              i_ready_busy_n,
  input wire logic              o_busy,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire read_mode_type     o_mode,
  input wire logic [ADDR_W-1:0] o_addr,
  input wire logic [DATA_W-1:0] o_data_bus,
  input wire logic              o_data_oe,
  input wire logic              o_ce_n,
  input wire logic              o_oe_n,
  input wire logic              o_we_n,
  input wire logic              o_reset_powerdown_n
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  sequence strobe_end; $rose(o_we_n); endsequence
  sequence held; o_data_oe && $stable(o_addr) && $stable(o_data_bus); endsequence
  // busy is seen through a two-flop sync plus a register, so four samples
  a_read_gate: assert property (!o_oe_n |-> !o_ce_n && !o_data_oe && o_we_n) else $error("bad read");
  a_write_gate: assert property (!o_we_n |-> !o_ce_n && o_data_oe) else $error("bad write");
  a_write_latch: assert property (strobe_end |-> held) else $error("data moved");
  a_reset_mode: assert property ($fell(i_rst) |-> o_mode == rmode_array) else $error("mode");
  a_busy_set: assert property (!i_ready_busy_n [*4] |-> o_busy) else $error("busy");
  a_busy_clear: assert property (i_ready_busy_n [*4] |-> !o_busy) else $error("idle");
  a_pd_width: assert property ($fell(o_reset_powerdown_n) |-> !o_reset_powerdown_n [*3]) else $error("pd");
  a_pd_quiet: assert property (!o_reset_powerdown_n |-> o_ce_n) else $error("select in pd");
  a_low_byte: assert property ($changed(o_rdata) && o_mode != rmode_array |-> o_rdata[DATA_W-1:8] == '0)
    else $error("upper byte");
endmodule
bind flash_host flash_host_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_chk (.*);

// >>> tb/flash_host_tb.sv
`timescale 1ns/10ps
module flash_host_tb;
  import flash_host_pkg::*;
  logic          i_clk_sys = 1'h0, i_rst = 1'h1, i_req = 1'h0, i_set_mode = 1'h0, i_wp_n = 1'h1, vpp_ok = 1'h1;
  op_type        i_op = op_read;
  read_mode_type i_mode = rmode_array, o_mode;
  logic [19:0]   i_addr = 20'h0, o_addr;
  logic [15:0]   i_wdata = 16'h0, i_wdata2 = 16'h0, i_data_bus, o_rdata, o_data_bus, dq;
  logic          i_ready_busy_n, o_ready, o_done, o_busy, o_data_oe, o_ce_n, o_oe_n, o_we_n;
  logic          o_reset_powerdown_n, o_wp_n;
  int            fails = 0, tests_run = 0;
  `define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
  always #20 i_clk_sys = ~i_clk_sys;
  assign i_data_bus = o_data_oe ? o_data_bus : dq;
  flash_host i_dut (.*);
  flash_dev_model i_dev (.i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n), .i_rp_n(o_reset_powerdown_n),
    .i_wp_n(o_wp_n), .i_vpp_ok(vpp_ok), .i_addr(o_addr), .i_dq(i_data_bus), .o_dq(dq),
    .o_ready_busy_n(i_ready_busy_n));
  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wait_lvl(ref logic s, input logic v);
    for (int n = 0; s !== v; n++)
    begin
      @(negedge i_clk_sys);
      if (n > 999)
      begin
        fails++;
        stop_test();
      end
    end
  endtask
  // inputs stay put until done, since the second data word is read late
  task automatic run(op_type op, logic [19:0] a, logic [15:0] d1, d2, logic sm, read_mode_type m);
    wait_lvl(o_ready, 1'h1);
    @(posedge i_clk_sys);
    i_req <= 1'h1;
    {i_op, i_addr, i_wdata, i_wdata2, i_set_mode, i_mode} <= {op, a, d1, d2, sm, m};
    @(posedge i_clk_sys);
    i_req <= 1'h0;
    wait_lvl(o_done, 1'h1);
    @(negedge i_clk_sys);
  endtask
  task automatic rd_chk(logic [19:0] a, logic [15:0] e);
    run(op_read, a, 16'h0, 16'h0, 1'h0, rmode_array);
    `CHK("rdata", e, o_rdata)
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_prog;
    `CHK("mode", rmode_array, o_mode)
    rd_chk(20'h5, 16'h5c3);
    run(op_two_step, 20'h5, 16'h11, 16'hbeef, 1'h0, rmode_array);
    wait_lvl(o_busy, 1'h1);
    wait_lvl(o_busy, 1'h0);
    rd_chk(20'h5, 16'hbeef);
    run(op_write, 20'h6, 16'hbeef, 16'h0, 1'h0, rmode_array);
    rd_chk(20'h6, 16'h6c3);
  endtask
  task automatic t_lock;
    vpp_ok <= 1'h0;
    run(op_two_step, 20'h7, 16'h11, 16'h1234, 1'h0, rmode_array);
    rd_chk(20'h7, 16'h7c3);
    run(op_write, 20'h0, 16'h44, 16'h0, 1'h1, rmode_status);
    `CHK("mode", rmode_status, o_mode)
    rd_chk(20'h0, 16'h80);
    run(op_write, 20'h0, 16'h33, 16'h0, 1'h1, rmode_ident);
    rd_chk(20'h0, 16'h5a);
    vpp_ok <= 1'h1;
    run(op_write, 20'h0, 16'h22, 16'h0, 1'h1, rmode_array);
    @(posedge i_clk_sys);
    i_wp_n <= 1'h0;
    run(op_two_step, 20'h1, 16'h11, 16'h1234, 1'h0, rmode_array);
    `CHK("wp", 1'h0, o_wp_n)
    rd_chk(20'h1, 16'h1c3);
    @(posedge i_clk_sys);
    i_wp_n <= 1'h1;
  endtask
  task automatic t_pd;
    run(op_two_step, 20'h8, 16'h11, 16'h4321, 1'h0, rmode_array);
    wait_lvl(o_busy, 1'h1);
    run(op_write, 20'h0, 16'h33, 16'h0, 1'h1, rmode_ident);
    run(op_reset, 20'h0, 16'h0, 16'h0, 1'h0, rmode_array);
    `CHK("busy", 1'h0, o_busy)
    `CHK("mode", rmode_array, o_mode)
    rd_chk(20'h8, 16'h4321);
  endtask
  initial
  begin
    repeat (6) @(posedge i_clk_sys);
    i_rst <= 1'h0;
    t_prog();
    t_lock();
    t_pd();
    stop_test();
  end
endmodule
